// >>> src/lcd_port_pkg.sv
// constants shared by the character display command port
// assumes a single 20 MHz clock; all times rounded to whole cycles
package lcd_port_pkg;
	localparam int CLK_PERIOD_NS = 50;
	// execution and start-up times in ns
	localparam int T_POWERUP_NS = 30_000_000;
	localparam int T_CLEAR_NS = 1_530_000;
	localparam int T_HOME_NS = 1_530_000;
	localparam int T_CMD_NS = 39_000;
	localparam int T_WRITE_NS = 43_000;
	// least times, rounded up
	localparam int CYC_POWERUP = (T_POWERUP_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int CYC_CLEAR = (T_CLEAR_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int CYC_HOME = (T_HOME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_CMD = (T_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_WRITE = (T_WRITE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	// display memory layout
	localparam logic [6:0] ROW1_FIRST = 7'h00;
	localparam logic [6:0] ROW1_LAST = 7'h27;
	localparam logic [6:0] ROW2_FIRST = 7'h40;
	localparam logic [6:0] ROW2_LAST = 7'h67;
	localparam logic [5:0] ROW_LAST_POS = 6'h27;
	localparam int VISIBLE_CHARS = 16;
	localparam int TEXT_AW = 7;
	localparam int GLYPH_AW = 6;
	localparam logic [6:0] SWEEP_LAST = 7'h7F;
	localparam logic [7:0] BLANK_CHAR = 8'h20;
	localparam logic [7:0] GLYPH_ZERO = 8'h00;
	// command codes and field positions
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam int ENTRY_DIR_BIT = 1;
	localparam int ENTRY_SHIFT_BIT = 0;
	localparam int CTRL_DISP_BIT = 2;
	localparam int CTRL_CURS_BIT = 1;
	localparam int CTRL_BLINK_BIT = 0;
	localparam int SHIFT_SC_BIT = 3;
	localparam int SHIFT_RL_BIT = 2;
	// values after reset
	localparam logic RST_INCREMENT = 1'b1;
	localparam logic RST_FOLLOW = 1'b0;
	localparam logic [2:0] RST_CONFIG = 3'h0;
endpackage

// >>> src/nibble_pair_assembler.sv
// joins two strobed nibbles into one byte with its register select
// assumes inputs synchronous to the clock and held until the first clock after the strobe falls
`timescale 1ns/1ns
module nibble_pair_assembler (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic accept_in,
	input wire logic nibble_strobe_line_in,
	input wire logic register_select_line_in,
	input wire logic [3:0] data_nibble_in,
	output logic byte_valid_out,
	output logic byte_rs_out,
	output logic [7:0] byte_out
);
	logic strobe_prev;
	logic second_half;
	logic [3:0] upper;
	logic strobe_fall;

	assign strobe_fall = strobe_prev && !nibble_strobe_line_in;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= nibble_strobe_line_in;
		end
	end

	// capture on the falling edge of the strobe
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !accept_in) begin
			second_half <= 1'b0;
			upper <= 4'h0;
			byte_valid_out <= 1'b0;
			byte_rs_out <= 1'b0;
			byte_out <= 8'h00;
		end else begin
			byte_valid_out <= 1'b0;
			if (strobe_fall && !second_half) begin
				upper <= data_nibble_in;
				second_half <= 1'b1;
			end else if (strobe_fall) begin
				byte_out <= {upper, data_nibble_in};
				byte_rs_out <= register_select_line_in;
				byte_valid_out <= 1'b1;
				second_half <= 1'b0;
			end
		end
	end
endmodule

// >>> src/simple_ram.sv
// single write port, single registered read port memory
// assumes one clock; contents are not reset, the owner sweeps them
`timescale 1ns/1ns
module simple_ram #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [DW-1:0] wdata_in,
	input wire logic [AW-1:0] raddr_in,
	output logic [DW-1:0] rdata_out
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge sys_clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule

// >>> src/char_lcd_nibble_command_port.sv
// character display command port: nibble bus in, display state out
// assumes host keeps start-up and execution waits; strobes while busy drop
// Behaviour
// - rows at 00-27 and 40-67
// - 40 positions per row, 16 visible
// - start-up clears RAM, sets entry mode
// - upper nibble first, then lower nibble
// - nibble captured on strobe high then low
// - execute only after second nibble
// - cursor, or glyph address when targeted, moves per entry direction after write
// - clear blanks, zero address, increment mode
// - return home zeroes address, homes cursor
// - entry mode: direction and shift bits
// - display, cursor, blink control bits
// - cursor or display shift, left/right
// - function configuration stored, 39 us
// - glyph address load targets glyph RAM
// - text address load targets text RAM
// - select high means data, low command
// - text address equals cursor position
`timescale 1ns/1ns
module char_lcd_nibble_command_port #(
	parameter int POWERUP_CYCLES = lcd_port_pkg::CYC_POWERUP,
	parameter int CLEAR_CYCLES = lcd_port_pkg::CYC_CLEAR,
	parameter int HOME_CYCLES = lcd_port_pkg::CYC_HOME
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic nibble_strobe_line_in,
	input wire logic register_select_line_in,
	input wire logic [3:0] data_nibble_in,
	input wire logic [6:0] text_read_addr_in,
	input wire logic [5:0] glyph_read_addr_in,
	output logic busy_out,
	output logic [6:0] cursor_addr_out,
	output logic [5:0] glyph_addr_out,
	output logic glyph_target_out,
	output logic increment_out,
	output logic display_follow_shift_bit_out,
	output logic [5:0] display_shift_out,
	output logic display_on_out,
	output logic cursor_on_out,
	output logic blink_on_out,
	output logic [2:0] function_config_out,
	output logic [7:0] text_read_data_out,
	output logic [7:0] glyph_read_data_out
);
	typedef enum logic [1:0] {
		ST_INIT_SWEEP,
		ST_CLEAR_SWEEP,
		ST_READY
	} state_t;

	state_t state;
	logic [6:0] sweep_idx;
	logic [lcd_port_pkg::CNT_W-1:0] cnt;
	logic [lcd_port_pkg::CNT_W-1:0] next_cnt;
	logic byte_valid;
	logic byte_rs;
	logic [7:0] cmd_byte;
	logic is_cmd;
	logic is_data;
	logic text_we;
	logic [6:0] text_waddr;
	logic [7:0] text_wdata;
	logic glyph_we;
	logic [5:0] glyph_waddr;
	logic [7:0] glyph_wdata;

	// next text address, hopping the gap between the two rows
	function automatic logic [6:0] step_addr(input logic [6:0] a,
		input logic up);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (up && a == lcd_port_pkg::ROW1_LAST) r = lcd_port_pkg::ROW2_FIRST;
		if (up && a == lcd_port_pkg::ROW2_LAST) r = lcd_port_pkg::ROW1_FIRST;
		if (!up && a == lcd_port_pkg::ROW1_FIRST) r = lcd_port_pkg::ROW2_LAST;
		if (!up && a == lcd_port_pkg::ROW2_FIRST) r = lcd_port_pkg::ROW1_LAST;
		return r;
	endfunction

	// window offset within a 40-position row; left moves it forward
	function automatic logic [5:0] step_offset(input logic [5:0] o,
		input logic left);
		logic [5:0] r;
		r = left ? o + 6'h01 : o - 6'h01;
		if (left && o == lcd_port_pkg::ROW_LAST_POS) r = 6'h00;
		if (!left && o == 6'h00) r = lcd_port_pkg::ROW_LAST_POS;
		return r;
	endfunction

	nibble_pair_assembler u_assembler (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.accept_in(!busy_out),
		.nibble_strobe_line_in(nibble_strobe_line_in),
		.register_select_line_in(register_select_line_in),
		.data_nibble_in(data_nibble_in),
		.byte_valid_out(byte_valid),
		.byte_rs_out(byte_rs),
		.byte_out(cmd_byte)
	);

	assign is_cmd = byte_valid && !byte_rs;
	assign is_data = byte_valid && byte_rs;

	// sweeps own the text write port, the start-up sweep also the glyph port; no byte can arrive while busy
	assign text_we = (state != ST_READY) || (is_data && !glyph_target_out);
	assign text_waddr = (state != ST_READY) ? sweep_idx : cursor_addr_out;
	assign text_wdata = (state != ST_READY) ? lcd_port_pkg::BLANK_CHAR :
		cmd_byte;
	assign glyph_we = (state == ST_INIT_SWEEP) || (is_data && glyph_target_out);
	assign glyph_waddr = (state == ST_INIT_SWEEP) ? sweep_idx[5:0] :
		glyph_addr_out;
	assign glyph_wdata = (state == ST_INIT_SWEEP) ? lcd_port_pkg::GLYPH_ZERO :
		cmd_byte;

	simple_ram #(.AW(lcd_port_pkg::TEXT_AW), .DW(8)) u_text_ram (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.we_in(text_we),
		.waddr_in(text_waddr),
		.wdata_in(text_wdata),
		.raddr_in(text_read_addr_in),
		.rdata_out(text_read_data_out)
	);

	simple_ram #(.AW(lcd_port_pkg::GLYPH_AW), .DW(8)) u_glyph_ram (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.we_in(glyph_we),
		.waddr_in(glyph_waddr),
		.wdata_in(glyph_wdata),
		.raddr_in(glyph_read_addr_in),
		.rdata_out(glyph_read_data_out)
	);

	// execution time for the byte just taken, less the load cycle
	always_comb begin
		next_cnt = lcd_port_pkg::CNT_W'(lcd_port_pkg::CYC_CMD - 1);
		if (byte_rs) begin
			next_cnt = lcd_port_pkg::CNT_W'(lcd_port_pkg::CYC_WRITE - 1);
		end else if (cmd_byte == lcd_port_pkg::CMD_CLEAR) begin
			next_cnt = lcd_port_pkg::CNT_W'(CLEAR_CYCLES - 1);
		end else if (cmd_byte[7:1] == 7'h01) begin
			next_cnt = lcd_port_pkg::CNT_W'(HOME_CYCLES - 1);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state <= ST_INIT_SWEEP;
			sweep_idx <= 7'h00;
		end else begin
			unique case (state)
				ST_INIT_SWEEP, ST_CLEAR_SWEEP: begin
					sweep_idx <= sweep_idx + 7'h01;
					if (sweep_idx == lcd_port_pkg::SWEEP_LAST) begin
						state <= ST_READY;
					end
				end
				ST_READY: begin
					if (is_cmd && cmd_byte == lcd_port_pkg::CMD_CLEAR) begin
						state <= ST_CLEAR_SWEEP;
						sweep_idx <= 7'h00;
					end
				end
			endcase
		end
	end

	// busy spans start-up, each execution time and any sweep
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			busy_out <= 1'b1;
			cnt <= lcd_port_pkg::CNT_W'(POWERUP_CYCLES - 1);
		end else if (byte_valid) begin
			busy_out <= 1'b1;
			cnt <= next_cnt;
		end else if (cnt != '0) begin
			cnt <= cnt - lcd_port_pkg::CNT_W'(1);
		end else if (state == ST_READY) begin
			busy_out <= 1'b0;
		end
	end

	// text cursor is the text address itself
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cursor_addr_out <= lcd_port_pkg::ROW1_FIRST;
			glyph_addr_out <= 6'h00;
			glyph_target_out <= 1'b0;
		end else if (is_data) begin
			if (glyph_target_out) begin
				glyph_addr_out <= increment_out ? glyph_addr_out + 6'h01 :
					glyph_addr_out - 6'h01;
			end else begin
				cursor_addr_out <= step_addr(cursor_addr_out, increment_out);
			end
		end else if (is_cmd) begin
			priority casez (cmd_byte)
				8'b1???????: begin
					cursor_addr_out <= cmd_byte[6:0];
					glyph_target_out <= 1'b0;
				end
				8'b01??????: begin
					glyph_addr_out <= cmd_byte[5:0];
					glyph_target_out <= 1'b1;
				end
				8'b0001????: begin
					if (!cmd_byte[lcd_port_pkg::SHIFT_SC_BIT]) begin
						cursor_addr_out <= step_addr(cursor_addr_out,
							cmd_byte[lcd_port_pkg::SHIFT_RL_BIT]);
					end
				end
				8'b0000001?, 8'b00000001: begin
					cursor_addr_out <= lcd_port_pkg::ROW1_FIRST;
					glyph_target_out <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// entry mode, window offset, display control and configuration
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			increment_out <= lcd_port_pkg::RST_INCREMENT;
			display_follow_shift_bit_out <= lcd_port_pkg::RST_FOLLOW;
			display_shift_out <= 6'h00;
			display_on_out <= 1'b0;
			cursor_on_out <= 1'b0;
			blink_on_out <= 1'b0;
			function_config_out <= lcd_port_pkg::RST_CONFIG;
		end else if (is_data) begin
			if (display_follow_shift_bit_out && !glyph_target_out) begin
				display_shift_out <= step_offset(display_shift_out,
					increment_out);
			end
		end else if (is_cmd) begin
			priority casez (cmd_byte)
				8'b1???????, 8'b01??????: begin
				end
				8'b001?????: begin
					function_config_out <= cmd_byte[4:2];
				end
				8'b0001????: begin
					if (cmd_byte[lcd_port_pkg::SHIFT_SC_BIT]) begin
						display_shift_out <= step_offset(display_shift_out,
							!cmd_byte[lcd_port_pkg::SHIFT_RL_BIT]);
					end
				end
				8'b00001???: begin
					display_on_out <= cmd_byte[lcd_port_pkg::CTRL_DISP_BIT];
					cursor_on_out <= cmd_byte[lcd_port_pkg::CTRL_CURS_BIT];
					blink_on_out <= cmd_byte[lcd_port_pkg::CTRL_BLINK_BIT];
				end
				8'b000001??: begin
					increment_out <= cmd_byte[lcd_port_pkg::ENTRY_DIR_BIT];
					display_follow_shift_bit_out <=
						cmd_byte[lcd_port_pkg::ENTRY_SHIFT_BIT];
				end
				8'b0000001?: begin
					display_shift_out <= 6'h00;
				end
				8'b00000001: begin
					display_shift_out <= 6'h00;
					increment_out <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	property p_exec_after_byte;
		byte_valid |=> busy_out;
	endproperty
	a_exec_after_byte: assert property (p_exec_after_byte)
		else $error("no busy after a completed byte");

	property p_no_spurious_busy;
		!byte_valid && !busy_out |=> !busy_out;
	endproperty
	a_no_spurious_busy: assert property (p_no_spurious_busy)
		else $error("busy rose without a byte");

	property p_row_wrap;
		is_data && !glyph_target_out && increment_out &&
			cursor_addr_out == 7'h27 |=> cursor_addr_out == 7'h40;
	endproperty
	a_row_wrap: assert property (p_row_wrap)
		else $error("row one did not continue into row two");

	property p_write_moves;
		is_data && !glyph_target_out |=> cursor_addr_out ==
			step_addr($past(cursor_addr_out), $past(increment_out));
	endproperty
	a_write_moves: assert property (p_write_moves)
		else $error("cursor did not follow the entry direction");

	property p_clear;
		is_cmd && cmd_byte == 8'h01 |=> cursor_addr_out == 7'h00 &&
			increment_out && display_shift_out == 6'h00 &&
			state == ST_CLEAR_SWEEP ##127 state == ST_CLEAR_SWEEP ##1
			state == ST_READY;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not home and blank");

	property p_home;
		is_cmd && cmd_byte[7:1] == 7'h01 |=> cursor_addr_out == 7'h00 &&
			state == ST_READY;
	endproperty
	a_home: assert property (p_home)
		else $error("return home misbehaved");

	property p_entry;
		is_cmd && cmd_byte[7:2] == 6'h01 |=>
			increment_out == $past(cmd_byte[1]) &&
			display_follow_shift_bit_out == $past(cmd_byte[0]);
	endproperty
	a_entry: assert property (p_entry)
		else $error("entry mode bits not taken");

	property p_control;
		is_cmd && cmd_byte[7:3] == 5'h01 |=>
			{display_on_out, cursor_on_out, blink_on_out} ==
			$past(cmd_byte[2:0]);
	endproperty
	a_control: assert property (p_control)
		else $error("display control bits not taken");

	property p_glyph_addr;
		is_cmd && cmd_byte[7:6] == 2'b01 |=> glyph_target_out &&
			glyph_addr_out == $past(cmd_byte[5:0]);
	endproperty
	a_glyph_addr: assert property (p_glyph_addr)
		else $error("glyph address not loaded");

	property p_text_addr;
		is_cmd && cmd_byte[7] |=> !glyph_target_out &&
			cursor_addr_out == $past(cmd_byte[6:0]);
	endproperty
	a_text_addr: assert property (p_text_addr)
		else $error("text address not loaded");

	property p_startup;
		$fell(reset_in) |-> busy_out [*8];
	endproperty
	a_startup: assert property (@(posedge sys_clk_in) p_startup)
		else $error("accepting transfers during start-up");

	c_data_write: cover property (is_data && !glyph_target_out);
	c_glyph_write: cover property (is_data && glyph_target_out);
	c_clear: cover property (is_cmd && cmd_byte == 8'h01);
endmodule

// >>> testbench/lcd_host_model.sv
// host model: sends one byte as two strobed nibbles per request
// assumes busy_in marks start-up and execution time of the port
`timescale 1ns/1ns
module lcd_host_model (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic go_in,
	input wire logic rs_in,
	input wire logic [7:0] byte_in,
	input wire logic busy_in,
	output logic done_out,
	output logic nibble_strobe_line_out,
	output logic register_select_line_out,
	output logic [3:0] data_nibble_out
);
	logic [2:0] step;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			step <= 3'h0;
			done_out <= 1'b0;
			nibble_strobe_line_out <= 1'b0;
			register_select_line_out <= 1'b0;
			data_nibble_out <= 4'hA;
		end else begin
			case (step)
			3'h0: begin
				if (go_in && !busy_in) begin
					nibble_strobe_line_out <= 1'b1;
					register_select_line_out <= rs_in;
					data_nibble_out <= byte_in[7:4];
					step <= 3'h1;
				end else begin
					// idle lines toggle so a stale value never looks valid
					register_select_line_out <= ~register_select_line_out;
					data_nibble_out <= ~data_nibble_out;
				end
			end
			3'h1: begin
				nibble_strobe_line_out <= 1'b0;
				step <= 3'h2;
			end
			3'h2: begin
				nibble_strobe_line_out <= 1'b1;
				register_select_line_out <= rs_in;
				data_nibble_out <= byte_in[3:0];
				step <= 3'h3;
			end
			3'h3: begin
				nibble_strobe_line_out <= 1'b0;
				done_out <= 1'b1;
				step <= 3'h4;
			end
			default: begin
				done_out <= 1'b0;
				step <= 3'h0;
			end
			endcase
		end
	end
endmodule

// >>> testbench/test_char_lcd_nibble_command_port.sv
// bench for the display command port: byte sends through the host model
// assumes shortened start-up and clear times set by parameters below
`timescale 1ns/1ns
`define CHK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
		end \
	end
module test_char_lcd_nibble_command_port;
	localparam int PU = 200;
	localparam int CLR = 150;
	localparam int CMD = lcd_port_pkg::CYC_CMD;
	localparam int WR = lcd_port_pkg::CYC_WRITE;
	localparam int LIMIT = 60000;
	logic sys_clk, reset, go, rs_req, done, strobe, rs_line, busy;
	logic [7:0] byte_req, tdata, gdata, d;
	logic [3:0] nibble;
	logic [6:0] taddr, cursor;
	logic [5:0] gaddr, glyph_addr, shift;
	logic glyph_target, increment, follow, disp_on, curs_on, blink_on;
	logic [2:0] config_bits;
	int mismatches, checks_done, cycles, i, w;

	lcd_host_model u_host (.sys_clk_in(sys_clk), .reset_in(reset),
		.go_in(go), .rs_in(rs_req), .byte_in(byte_req), .busy_in(busy),
		.done_out(done), .nibble_strobe_line_out(strobe),
		.register_select_line_out(rs_line), .data_nibble_out(nibble));

	char_lcd_nibble_command_port #(.POWERUP_CYCLES(PU),
		.CLEAR_CYCLES(CLR), .HOME_CYCLES(CLR)) u_dut (
		.sys_clk_in(sys_clk), .reset_in(reset),
		.nibble_strobe_line_in(strobe), .register_select_line_in(rs_line),
		.data_nibble_in(nibble), .text_read_addr_in(taddr),
		.glyph_read_addr_in(gaddr), .busy_out(busy),
		.cursor_addr_out(cursor), .glyph_addr_out(glyph_addr),
		.glyph_target_out(glyph_target), .increment_out(increment),
		.display_follow_shift_bit_out(follow),
		.display_shift_out(shift), .display_on_out(disp_on),
		.cursor_on_out(curs_on), .blink_on_out(blink_on),
		.function_config_out(config_bits), .text_read_data_out(tdata),
		.glyph_read_data_out(gdata));

	always #25 sys_clk = ~sys_clk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			test_done();
		end
	end

	// tolerance covers where busy is first seen relative to its edge
	function automatic logic near(input int n, input int t);
		return n + 2 >= t && n <= t + 2;
	endfunction

	task automatic send(input logic rs, input logic [7:0] b, output int n);
		int k;
		k = 0;
		n = 1;
		@(posedge sys_clk);
		go <= 1'b1;
		rs_req <= rs;
		byte_req <= b;
		do begin
			@(negedge sys_clk);
			k++;
		end while (done !== 1'b1 && k < 2000);
		@(posedge sys_clk);
		go <= 1'b0;
		k = 0;
		while (busy !== 1'b1 && k < 8) begin
			@(negedge sys_clk);
			k++;
		end
		while (busy === 1'b1 && n < 40000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic cmd(input logic [7:0] b, input int t);
		int n;
		send(1'b0, b, n);
		`CHK("command busy time", 1'b1, near(n, t))
	endtask

	task automatic wr(input logic [7:0] b);
		int n;
		send(1'b1, b, n);
		`CHK("write busy time", 1'b1, near(n, WR))
	endtask

	task automatic rd(input logic g, input logic [6:0] a,
		output logic [7:0] q);
		@(posedge sys_clk);
		if (g) begin
			gaddr <= a[5:0];
		end else begin
			taddr <= a;
		end
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		q = g ? gdata : tdata;
	endtask

	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		go = 1'b0;
		rs_req = 1'b0;
		byte_req = 8'h00;
		taddr = 7'h00;
		gaddr = 6'h00;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		`CHK("busy at start", 1'b1, busy)
		`CHK("start increment", 1'b1, increment)
		w = 1;
		while (busy === 1'b1 && w < 1000) begin
			@(negedge sys_clk);
			w++;
		end
		`CHK("start-up length", 1'b1, near(w, PU))
		rd(1'b0, 7'h00, d);
		`CHK("text swept", 8'h20, d)
		rd(1'b0, 7'h67, d);
		`CHK("text swept end", 8'h20, d)
		rd(1'b1, 7'h3F, d);
		`CHK("glyph swept", 8'h00, d)
		cmd(8'h28, CMD);
		`CHK("function config", 3'h2, config_bits)
		for (i = 0; i < 8; i++) begin
			cmd(8'h08 | 8'(i), CMD);
			`CHK("display bits", 3'(i), {disp_on, curs_on, blink_on})
		end
		// a write first, so that clear has a cursor to bring home
		wr(8'h30);
		`CHK("cursor before clear", 7'h01, cursor)
		cmd(8'h04, CMD);
		`CHK("decrement set", 1'b0, increment)
		cmd(8'h01, CLR);
		`CHK("clear cursor", 7'h00, cursor)
		`CHK("clear increment", 1'b1, increment)
		wr(8'h41);
		wr(8'h42);
		`CHK("cursor after writes", 7'h02, cursor)
		rd(1'b0, 7'h00, d);
		`CHK("text 00", 8'h41, d)
		rd(1'b0, 7'h01, d);
		`CHK("text 01", 8'h42, d)
		cmd(8'hA7, CMD);
		`CHK("address set", 7'h27, cursor)
		wr(8'h43);
		`CHK("row wrap up", 7'h40, cursor)
		rd(1'b0, 7'h27, d);
		`CHK("text 27", 8'h43, d)
		cmd(8'h04, CMD);
		wr(8'h44);
		`CHK("row wrap down", 7'h27, cursor)
		rd(1'b0, 7'h40, d);
		`CHK("text 40", 8'h44, d)
		cmd(8'h80, CMD);
		wr(8'h45);
		`CHK("wrap below zero", 7'h67, cursor)
		cmd(8'h07, CMD);
		`CHK("entry inc", 1'b1, increment)
		`CHK("entry follow", 1'b1, follow)
		wr(8'h46);
		`CHK("follow shift", 6'h01, shift)
		`CHK("follow cursor", 7'h00, cursor)
		cmd(8'h14, CMD);
		`CHK("cursor right", 7'h01, cursor)
		`CHK("window kept", 6'h01, shift)
		cmd(8'h18, CMD);
		`CHK("display left", 6'h02, shift)
		rd(1'b0, 7'h67, d);
		`CHK("ram kept", 8'h46, d)
		cmd(8'h03, CLR);
		`CHK("home cursor", 7'h00, cursor)
		`CHK("home window", 6'h00, shift)
		cmd(8'h1C, CMD);
		`CHK("window wrap", 6'h27, shift)
		cmd(8'h01, CLR);
		rd(1'b0, 7'h00, d);
		`CHK("clear blanks", 8'h20, d)
		`CHK("clear window", 6'h00, shift)
		cmd(8'h7F, CMD);
		`CHK("glyph addr", 6'h3F, glyph_addr)
		`CHK("glyph target", 1'b1, glyph_target)
		wr(8'h15);
		`CHK("glyph step", 6'h00, glyph_addr)
		`CHK("cursor still", 7'h00, cursor)
		rd(1'b1, 7'h3F, d);
		`CHK("glyph data", 8'h15, d)
		cmd(8'h85, CMD);
		`CHK("text target", 1'b0, glyph_target)
		`CHK("text addr", 7'h05, cursor)
		test_done();
	end
endmodule
